// *** ddrpb_ctrl_model.sv ***
// memory controller model driving commands and write data, capturing reads
`timescale 1ns/1ns
module ddrpb_ctrl_model
    import ddrpb_pkg::*;
(
    input  wire logic              true_clock,
    output logic                   clock_enable,
    output logic                   chip_select_n,
    output logic                   row_strobe_n,
    output logic                   col_strobe_n,
    output logic                   write_enable_n,
    output logic      [BANK_W-1:0] bank_addr,
    output logic      [ADDR_W-1:0] addr,
    output logic                   write_mask,
    output logic      [DQ_W-1:0]   dq_in,
    output logic                   strobe_in,
    input  wire logic [DQ_W-1:0]   dq_out,
    input  wire logic              dq_oe_n
);
    logic [DQ_W:0]   wq[$];
    logic [DQ_W-1:0] rq[$];
    logic            wr_on = 1'b0;
    initial begin
        {clock_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 5'h1f;
        {bank_addr, addr, write_mask, dq_in} = '0;
    end
    // write strobe shifted off the data edges
    assign #2 strobe_in = wr_on & true_clock;
    always @(negedge true_clock) begin
        if (!wr_on) begin
            write_mask <= ~write_mask;
        end
    end
    always @(true_clock) begin
        #1;
        if (dq_oe_n === 1'b0) begin
            rq.push_back(dq_out);
        end
    end
    task automatic cmd(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
        @(posedge true_clock);
        // idle edges alternate deselect with a disabled clock under a read code
        {row_strobe_n, col_strobe_n, write_enable_n} <= (&c && clock_enable) ? 3'h5 : c;
        clock_enable  <= !(&c) || !clock_enable;
        chip_select_n <= &c && !clock_enable;
        bank_addr     <= (&c) ? ~bank_addr : b;
        addr          <= (&c) ? ~addr : a;
    endtask
    task automatic burst(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a, input int s);
        cmd(c, b, a);
        fork
            begin
                if (s > 0) begin
                    repeat (s - 1) cmd(3'h7, '0, '0);
                    cmd((s % 2) ? 3'h6 : ((s % 4) ? 3'h2 : 3'h1), b, '0);
                end
                repeat (8) cmd(3'h7, '0, '0);
            end
            begin
                @(posedge true_clock);
                while (wq.size() > 0) begin
                    @(posedge true_clock);
                    wr_on = 1'b1;
                    {write_mask, dq_in} <= wq.pop_front();
                    @(negedge true_clock);
                    {write_mask, dq_in} <= wq.pop_front();
                end
                @(posedge true_clock);
                wr_on = 1'b0;
                dq_in <= ~dq_in;
            end
        join
    endtask
endmodule // ddrpb_ctrl_model

// *** ddrpb_device.sv ***
// device side of a 2n-prefetch double data rate dram data and command interface
`timescale 1ns/1ns

module ddrpb_device
    import ddrpb_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              true_clock,
    input  wire logic              complement_clock,
    input  wire logic              clock_enable,
    input  wire logic              chip_select_n,
    input  wire logic              row_strobe_n,
    input  wire logic              col_strobe_n,
    input  wire logic              write_enable_n,
    input  wire logic [BANK_W-1:0] bank_addr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              write_mask,
    input  wire logic [DQ_W-1:0]   dq_in,
    output logic      [DQ_W-1:0]   dq_out,
    output logic                   dq_oe_n,
    input  wire logic              strobe_in,
    output logic                   strobe_out,
    output logic                   strobe_oe_n,
    output logic                   link_busy
);

    ddrpb_link_s      link_reg;
    ddrpb_link_s      link_next;
    ddrpb_ref_s       ref_reg;
    ddrpb_ref_s       ref_next;
    logic [1:0]       lrst_sync_reg;
    logic             link_reset;
    logic [DQ_W-1:0]  word0_reg;
    logic             mask0_reg;
    logic [DQ_W-1:0]  mem [0:MEM_DEPTH-1];
    ddrpb_cmd_e       cmd;
    logic             intr;
    logic             fetch_en;
    logic [BANK_W-1:0] f_bank;
    logic [ROW_W-1:0] f_row;
    logic [COL_W-1:0] f_col;
    logic [2:0]       f_idx;
    logic [COL_W-1:0] f_c0;
    logic [COL_W-1:0] f_c1;
    logic             wr_en0;
    logic             wr_en1;
    logic [7:0]       wr_a0;
    logic [7:0]       wr_a1;
    logic [DQ_W-1:0]  wr_d1;

    // ref_clk domain: reset hold and busy synchroniser
    always_comb begin
        ref_next           = ref_reg;
        ref_next.rst_hold  = reset;
        ref_next.busy_sync = {ref_reg.busy_sync[0], link_reg.busy};
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ref_reg <= '{rst_hold: 1'b1, busy_sync: 2'h0};
        end else begin
            ref_reg <= ref_next;
        end
    end

    assign link_busy = ref_reg.busy_sync[1];

    // reset carried into the link clock domain
    always_ff @(posedge true_clock) begin
        lrst_sync_reg <= {lrst_sync_reg[0], ref_reg.rst_hold};
    end

    assign link_reset = lrst_sync_reg[1];

    // command decode on the rising true clock
    always_comb begin
        cmd = CMD_NOP;
        if (clock_enable && !chip_select_n) begin
            unique case ({row_strobe_n, col_strobe_n, write_enable_n})
                3'b011:  cmd = CMD_ACT;
                3'b101:  cmd = CMD_RD;
                3'b100:  cmd = CMD_WR;
                3'b110:  cmd = CMD_BST;
                3'b010:  cmd = CMD_PRE;
                3'b000:  cmd = CMD_MODE;
                3'b001:  cmd = CMD_REF;
                3'b111:  cmd = CMD_NOP;
            endcase
        end
        intr = (cmd != CMD_NOP) && (cmd != CMD_ACT);
    end

    // first word of each write pair taken on the falling true clock
    always_ff @(negedge true_clock) begin
        word0_reg <= dq_in;
        mask0_reg <= write_mask;
    end

    always_comb begin
        link_next = link_reg;
        fetch_en  = 1'b0;
        f_bank    = link_reg.rd_bank;
        f_row     = link_reg.rd_row;
        f_col     = link_reg.rd_col;
        f_idx     = link_reg.rd_idx;
        wr_en0    = 1'b0;
        wr_en1    = 1'b0;
        wr_a0     = {link_reg.wr_bank, link_reg.wr_row,
                     ddrpb_col(link_reg.wr_col, link_reg.wr_idx, link_reg.bl_pairs, link_reg.ilv)};
        wr_a1     = {link_reg.wr_bank, link_reg.wr_row,
                     ddrpb_col(link_reg.wr_col, link_reg.wr_idx + 3'h1, link_reg.bl_pairs, link_reg.ilv)};
        wr_d1     = dq_in;

        // read pipeline advances one stage per rising true clock edge
        link_next.rd_vld[0]  = 1'b0;
        link_next.rd_pair[0] = '0;
        for (int k = 1; k < RD_STAGES; k++) begin
            link_next.rd_vld[k]  = link_reg.rd_vld[k-1];
            link_next.rd_pair[k] = link_reg.rd_pair[k-1];
        end
        link_next.rd_post = link_reg.rd_vld[CAS_LAT];

        // read continuation: each quiet edge fetches one more pair
        if (link_reg.rd_left != 3'h0) begin
            if (intr) begin
                link_next.rd_left = 3'h0;
            end else begin
                fetch_en          = 1'b1;
                link_next.rd_left = link_reg.rd_left - 3'h1;
                link_next.rd_idx  = link_reg.rd_idx + 3'h2;
            end
        end

        // write pair completes at its closing edge, array written last
        if (link_reg.wr_data_on) begin
            wr_en0               = !mask0_reg;
            wr_en1               = !write_mask;
            link_next.wr_idx     = link_reg.wr_idx + 3'h2;
            link_next.wr_left    = intr ? 3'h0 : link_reg.wr_left - 3'h1;
            link_next.wr_data_on = (link_reg.wr_left > 3'h1) && !intr;
        end
        if (link_reg.wr_arm) begin
            link_next.wr_arm     = 1'b0;
            link_next.wr_data_on = 1'b1;
            if (intr) begin
                link_next.wr_left = 3'h1;
            end
        end

        unique case (cmd)
            CMD_ACT: begin
                link_next.open[bank_addr] = 1'b1;
                link_next.rows[bank_addr] = addr[ROW_W-1:0];
            end
            CMD_PRE: begin
                if (addr[AP_BIT]) begin
                    link_next.open = '0;
                end else begin
                    link_next.open[bank_addr] = 1'b0;
                end
            end
            CMD_MODE: begin
                unique case (addr[BL_LSB +: 3])
                    BL_CODE_2: link_next.bl_pairs = PAIRS_2;
                    BL_CODE_4: link_next.bl_pairs = PAIRS_4;
                    BL_CODE_8: link_next.bl_pairs = PAIRS_8;
                    default:   link_next.bl_pairs = link_reg.bl_pairs;
                endcase
                link_next.ilv = addr[BT_BIT];
            end
            CMD_RD: begin
                fetch_en          = 1'b1;
                f_bank            = bank_addr;
                f_row             = link_reg.rows[bank_addr];
                f_col             = addr[COL_W-1:0];
                f_idx             = 3'h0;
                link_next.rd_bank = bank_addr;
                link_next.rd_row  = link_reg.rows[bank_addr];
                link_next.rd_col  = addr[COL_W-1:0];
                link_next.rd_left = link_reg.bl_pairs - 3'h1;
                link_next.rd_idx  = 3'h2;
                if (addr[AP_BIT]) begin
                    link_next.open[bank_addr] = 1'b0;
                end
            end
            CMD_WR: begin
                link_next.wr_arm  = 1'b1;
                link_next.wr_bank = bank_addr;
                link_next.wr_row  = link_reg.rows[bank_addr];
                link_next.wr_col  = addr[COL_W-1:0];
                link_next.wr_left = link_reg.bl_pairs;
                link_next.wr_idx  = 3'h0;
                if (addr[AP_BIT]) begin
                    link_next.open[bank_addr] = 1'b0;
                end
            end
            CMD_BST, CMD_REF, CMD_NOP: begin
            end
        endcase

        // one internal access delivers a word pair in burst order
        f_c0 = ddrpb_col(f_col, f_idx, link_reg.bl_pairs, link_reg.ilv);
        f_c1 = ddrpb_col(f_col, f_idx + 3'h1, link_reg.bl_pairs, link_reg.ilv);
        if (fetch_en) begin
            link_next.rd_vld[0]  = 1'b1;
            link_next.rd_pair[0] = {mem[{f_bank, f_row, f_c1}], mem[{f_bank, f_row, f_c0}]};
        end

        link_next.busy = (link_next.rd_left != 3'h0) || (|link_next.rd_vld) || link_next.rd_post
                         || link_next.wr_arm || link_next.wr_data_on;
    end

    always_ff @(posedge true_clock) begin
        if (link_reset) begin
            link_reg          <= '0;
            link_reg.bl_pairs <= PAIRS_RESET;
            link_reg.ilv      <= ILV_RESET;
        end else begin
            link_reg <= link_next;
        end
    end

    // merged write pair stored in one access
    always_ff @(posedge true_clock) begin
        if (wr_en0) begin
            mem[wr_a0] <= word0_reg;
        end
        if (wr_en1) begin
            mem[wr_a1] <= wr_d1;
        end
    end

    // data and strobe launched together, first word in the high phase
    assign dq_out      = true_clock ? link_reg.rd_pair[CAS_LAT][DQ_W-1:0]
                                    : link_reg.rd_pair[CAS_LAT][2*DQ_W-1:DQ_W];
    assign dq_oe_n     = !link_reg.rd_vld[CAS_LAT];
    assign strobe_out  = link_reg.rd_vld[CAS_LAT] & true_clock;
    // preamble stage, toggling stages and postamble all drive the strobe
    assign strobe_oe_n = !(link_reg.rd_vld[CAS_LAT] | link_reg.rd_vld[CAS_LAT-1]
                           | link_reg.rd_post);

endmodule // ddrpb_device

// *** ddrpb_device_sva.sv ***
// assertion checker for the ddr prefetch burst device pins
`timescale 1ns/1ns
module ddrpb_device_sva
    import ddrpb_pkg::*;
(
    input wire logic reset,
    input wire logic true_clock,
    input wire logic clock_enable,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_enable_n,
    input wire logic dq_oe_n,
    input wire logic strobe_out,
    input wire logic strobe_oe_n
);
    default clocking cb @(posedge true_clock);
    endclocking
    default disable iff (reset);
    wire logic sel = clock_enable && !chip_select_n;
    wire logic rd  = sel && row_strobe_n && !col_strobe_n && write_enable_n;
    wire logic wr  = sel && row_strobe_n && !col_strobe_n && !write_enable_n;
    wire logic burst_stop_command = sel && row_strobe_n && col_strobe_n && !write_enable_n;
    a_data_has_strobe: assert property (!dq_oe_n |-> !strobe_oe_n) else $error("data without strobe");
    a_strobe_aligned: assert property (@(negedge true_clock) !dq_oe_n |-> strobe_out) else $error("strobe late");
    a_strobe_idle_low: assert property (@(negedge true_clock) dq_oe_n |-> !strobe_out) else $error("idle toggle");
    a_preamble_first: assert property ($fell(strobe_oe_n) |-> dq_oe_n ##1 !dq_oe_n) else $error("no preamble");
    a_postamble_low: assert property ($rose(dq_oe_n) |-> !strobe_oe_n ##1 strobe_oe_n) else $error("bad postamble");
    a_read_answer: assert property (rd |-> ##2 !strobe_oe_n ##1 !dq_oe_n) else $error("read pair missing");
    a_stop_ends_read: assert property (burst_stop_command |-> ##3 dq_oe_n) else $error("read not stopped");
    a_reads_no_gap: assert property (rd ##1 rd |-> ##2 (!dq_oe_n && !strobe_oe_n) [*2]) else $error("read gap");
    a_write_no_drive: assert property (wr |-> ##1 dq_oe_n [*4]) else $error("driven in write");
    c_reads_b2b: cover property (rd ##1 rd);
    c_read_stop: cover property (rd ##1 burst_stop_command);
    c_write: cover property (wr);
endmodule // ddrpb_device_sva

bind ddrpb_device ddrpb_device_sva u_sva (
    .reset(reset), .true_clock(true_clock), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
    .dq_oe_n(dq_oe_n), .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n)
);

// *** ddrpb_device_tb.sv ***
// self-checking testbench for the ddr prefetch burst device
`timescale 1ns/1ns
module ddrpb_device_tb
    import ddrpb_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              true_clock = 1'b0;
    logic              reset = 1'b1;
    logic              clock_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
    logic              write_mask, strobe_in, dq_oe_n, strobe_out, strobe_oe_n, link_busy;
    logic [BANK_W-1:0] bank_addr;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_in, dq_out;
    logic [DQ_W-1:0]   mem [0:255];
    logic [ROW_W-1:0]  row_of [0:3];
    int                error_cnt = 0, checks = 0, seed = 94, pairs = 1, b, c, busy_seen = 0;
    logic              ilv = 1'b0;
    initial forever #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) busy_seen |= int'(link_busy === 1'b1);
    initial begin
        #7;
        forever #3 true_clock = ~true_clock;
    end
    ddrpb_device uut (
        .ref_clk(ref_clk), .reset(reset), .true_clock(true_clock), .complement_clock(~true_clock),
        .clock_enable(clock_enable), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n), .bank_addr(bank_addr), .addr(addr),
        .write_mask(write_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .strobe_in(strobe_in),
        .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n), .link_busy(link_busy)
    );
    ddrpb_ctrl_model ctl (
        .true_clock(true_clock), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
        .bank_addr(bank_addr), .addr(addr), .write_mask(write_mask), .dq_in(dq_in), .strobe_in(strobe_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n)
    );
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // memory index of word i of a burst starting at column st
    function automatic int at(int bk, int st, int i);
        int m;
        m = 2 * pairs - 1;
        return bk * 64 + row_of[bk] * 16 + (ilv ? (st ^ i) : ((st & ~m) | ((st + i) & m)));
    endfunction
    task automatic mode(input logic [2:0] code, input logic il);
        ctl.burst(3'h0, '0, {8'h0, il, code}, 0);
        pairs = 1 << (code - 1);
        ilv = il;
    endtask
    task automatic wr(input int bk, input int st, input int e, input logic mk);
        int kept;
        logic [8:0] w;
        kept = (e == 0) ? pairs : ((e < 3) ? 1 : e - 1);
        kept = (kept > pairs) ? pairs : kept;
        for (int i = 0; i < 2 * pairs; i++) begin
            w = 9'($random(seed));
            w[8] = w[8] & mk;
            ctl.wq.push_back(w);
            if (!w[8] && i < 2 * kept) mem[at(bk, st, i)] = w[7:0];
        end
        ctl.burst(3'h4, 2'(bk), ADDR_W'(st), e);
    endtask
    task automatic rd(input int bk, input int st, input int s);
        int n;
        n = (s > 0 && s < pairs) ? 2 * s : 2 * pairs;
        ctl.rq.delete();
        ctl.burst(3'h5, 2'(bk), ADDR_W'(st), s);
        chk("read count", 16'(ctl.rq.size()), 16'(n));
        for (int i = 0; i < n && i < ctl.rq.size(); i++) begin
            chk("read word", {8'h0, ctl.rq[i]}, {8'h0, mem[at(bk, st, i)]});
        end
    endtask
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("idle pins", {13'h0, link_busy, dq_oe_n, strobe_oe_n}, 16'h3);
        for (int m = 0; m < 6; m++) begin
            mode(3'(m / 2 + 1), 1'(m % 2));
            b = $random(seed) & 3;
            c = $random(seed) & 3;
            ctl.burst(3'h3, 2'(b), ADDR_W'(c), 0);
            row_of[b] = 2'(c);
            c = $random(seed) & 15;
            wr(b, c, 0, 1'b0);
            wr(b, c, 0, 1'b1);
            for (int s = 0; s < pairs; s++) begin
                rd(b, c, s);
            end
            wr(b, c ^ 1, 4 - m % 4, 1'b1);
            rd(b, c ^ 1, 0);
        end
        ctl.rq.delete();
        ctl.cmd(3'h5, 2'(b), ADDR_W'(c));
        ctl.burst(3'h5, 2'(b), ADDR_W'(c ^ 1), 0);
        chk("b2b count", 16'(ctl.rq.size()), 16'(2 + 2 * pairs));
        for (int i = 0; i < 2 + 2 * pairs && i < ctl.rq.size(); i++) begin
            chk("b2b word", {8'h0, ctl.rq[i]}, {8'h0, mem[i < 2 ? at(b, c, i) : at(b, c ^ 1, i - 2)]});
        end
        repeat (3) @(negedge ref_clk);
        chk("end idle", {13'h0, link_busy, dq_oe_n, strobe_oe_n}, 16'h3);
        chk("busy seen", 16'(busy_seen), 16'h1);
        report_and_stop();
    end
endmodule // ddrpb_device_tb

// *** ddrpb_pkg.sv ***
// constants, command codes and state layouts for the ddr prefetch burst interface
package ddrpb_pkg;

    localparam int DQ_W      = 8;
    localparam int BANK_W    = 2;
    localparam int ROW_W     = 2;
    localparam int COL_W     = 4;
    localparam int ADDR_W    = 12;
    localparam int NUM_BANKS = 4;
    localparam int MEM_DEPTH = NUM_BANKS * (1 << ROW_W) * (1 << COL_W);

    // cycles of true_clock from read command edge to first data edge
    localparam int CAS_LAT   = 2;
    // cycles of true_clock from write command edge to first data cycle
    localparam int WR_LAT    = 1;
    localparam int RD_STAGES = CAS_LAT + 1;

    // address bit positions
    localparam int AP_BIT    = 10;
    localparam int BL_LSB    = 0;
    localparam int BT_BIT    = 3;

    // burst length codes in the mode word
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;

    // burst length kept as a count of word pairs
    localparam logic [2:0] PAIRS_2     = 3'h1;
    localparam logic [2:0] PAIRS_4     = 3'h2;
    localparam logic [2:0] PAIRS_8     = 3'h4;
    localparam logic [2:0] PAIRS_RESET = PAIRS_2;
    localparam logic       ILV_RESET   = 1'b0;

    typedef enum logic [7:0] {
        CMD_NOP  = 8'h01,
        CMD_ACT  = 8'h02,
        CMD_RD   = 8'h04,
        CMD_WR   = 8'h08,
        CMD_BST  = 8'h10,
        CMD_PRE  = 8'h20,
        CMD_MODE = 8'h40,
        CMD_REF  = 8'h80
    } ddrpb_cmd_e;

    typedef struct packed {
        logic [2:0]                           bl_pairs;
        logic                                 ilv;
        logic [NUM_BANKS-1:0]                 open;
        logic [NUM_BANKS-1:0][ROW_W-1:0]      rows;
        logic [BANK_W-1:0]                    rd_bank;
        logic [ROW_W-1:0]                     rd_row;
        logic [COL_W-1:0]                     rd_col;
        logic [2:0]                           rd_left;
        logic [2:0]                           rd_idx;
        logic [RD_STAGES-1:0]                 rd_vld;
        logic [RD_STAGES-1:0][2*DQ_W-1:0]     rd_pair;
        logic                                 rd_post;
        logic [BANK_W-1:0]                    wr_bank;
        logic [ROW_W-1:0]                     wr_row;
        logic [COL_W-1:0]                     wr_col;
        logic [2:0]                           wr_left;
        logic [2:0]                           wr_idx;
        logic                                 wr_arm;
        logic                                 wr_data_on;
        logic                                 busy;
    } ddrpb_link_s;

    typedef struct packed {
        logic       rst_hold;
        logic [1:0] busy_sync;
    } ddrpb_ref_s;

    // column of word idx within a burst, sequential or interleaved order
    function automatic logic [COL_W-1:0] ddrpb_col(
        input logic [COL_W-1:0] start,
        input logic [2:0]       idx,
        input logic [2:0]       pairs,
        input logic             ilv
    );
        logic [COL_W-1:0] mask;
        logic [COL_W-1:0] low;
        mask = COL_W'({pairs, 1'b0}) - 4'h1;
        low  = ilv ? (start ^ COL_W'(idx)) : (start + COL_W'(idx));
        return (start & ~mask) | (low & mask);
    endfunction

endpackage
